// file: rtl/dmx_defs.svh
// Purpose: constants of the direct move / resource / coprocessor execution unit
// Assumes: included by bare name; guarded against double inclusion
// Notes: definitions only
`ifndef DMX_DEFS_SVH
`define DMX_DEFS_SVH

// opcodes, upper byte of the first half-word
`define DMX_OP_LD_W      8'h08
`define DMX_OP_ST_W      8'h18
`define DMX_OP_DP_W      8'h0c
`define DMX_OP_PD_W      8'h1c
`define DMX_OP_PUSH_W    8'h0b
`define DMX_OP_POP_W     8'h1b
`define DMX_OP_LD_H      8'h09
`define DMX_OP_ST_H      8'h19
`define DMX_OP_DP_H      8'h0d
`define DMX_OP_PD_H      8'h1d
`define DMX_OP_LD_B      8'h0a
`define DMX_OP_ST_B      8'h1a
`define DMX_OP_DP_B      8'h0e
`define DMX_OP_PD_B      8'h1e
`define DMX_OP_RES_LD    8'hbc
`define DMX_OP_RES_ST    8'hbd
// coprocessor operate: upper twelve bits, channel in the low nibble
`define DMX_OP_COP       12'h9fc

// pointer steps
`define DMX_STEP_WORD    32'h0000_0004
`define DMX_STEP_HALF    32'h0000_0002
`define DMX_STEP_BYTE    32'h0000_0001

// fixed register numbers
`define DMX_REG_XFER     4'hd
`define DMX_REG_STACK    4'hf

// byte enables, big-endian lanes
`define DMX_BE_WORD      4'hf
`define DMX_BE_HALF_HI   4'hc
`define DMX_BE_HALF_LO   4'h3
`define DMX_BE_BYTE_TOP  4'h8

`endif

// file: rtl/dmx_exec.sv
// Purpose: executes direct moves, resource transfers and coprocessor operate
// Assumes: one memory access in flight; bus answers with mem_ack
// Notes: a and b counts are set by the memory and coprocessor answers
`timescale 1ns/100ps
`include "dmx_defs.svh"
module dmx_exec (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          reset,
   // instruction stream
   input  wire logic          insn_valid,
   input  wire logic [15:0]   insn_data,
   output logic               insn_ready,
   output logic               insn_done,
   output logic               insn_unknown,
   // general registers
   input  wire logic [31:0]   r13_value,
   input  wire logic [31:0]   r15_value,
   output logic [3:0]         gpr_rd_addr,
   input  wire logic [31:0]   gpr_rd_data,
   output logic               gpr_we,
   output logic [3:0]         gpr_waddr,
   output logic [31:0]        gpr_wdata,
   // condition flags
   output logic               flags_we,
   // memory bus
   output logic               mem_req,
   output logic               mem_we,
   output logic [31:0]        mem_addr,
   output logic [3:0]         mem_be,
   output logic [31:0]        mem_wdata,
   input  wire logic [31:0]   mem_rdata,
   input  wire logic          mem_ack,
   // resource channels
   output logic [3:0]         res_channel,
   output logic               res_re,
   input  wire logic [31:0]   res_rdata,
   output logic               res_we,
   output logic [31:0]        res_wdata,
   // coprocessors
   input  wire logic [15:0]   cop_present,
   input  wire logic [15:0]   cop_error,
   output logic               cop_req,
   output logic [3:0]         cop_channel,
   output logic [15:0]        cop_cmd,
   input  wire logic          cop_ack,
   output logic               trap_absent,
   output logic               trap_error
);
   import dmx_pkg::*;

   typedef struct packed {
      dmx_state_type state;
      dmx_kind_type  kind;
      dmx_size_type  size;
      logic          use_stack;
      logic [3:0]    ptr_reg;
      logic [31:0]   dir_addr;
      logic [31:0]   ptr_addr;
      logic [31:0]   ptr_next;
      logic [3:0]    chan;
      logic          mem_req;
      logic          mem_we;
      logic [31:0]   mem_addr;
      logic [3:0]    mem_be;
      logic [31:0]   mem_wdata;
      logic          gpr_we;
      logic [3:0]    gpr_waddr;
      logic [31:0]   gpr_wdata;
      logic          done;
      logic          unknown;
      logic          res_we;
      logic [31:0]   res_wdata;
      logic          cop_req;
      logic [15:0]   cop_cmd;
      logic          trap_absent;
      logic          trap_error;
   } dmx_exec_state_type;

   dmx_exec_state_type r;
   dmx_exec_state_type next_r;
   dmx_dec_type        dec;
   logic [31:0]        dir_w;
   logic [31:0]        ptr_base;
   logic [31:0]        step;
   logic [31:0]        ptr_a;
   logic [31:0]        ptr_n;
   logic               take;

   dmx_lane_if lane_bus ();

   dmx_lane u_lane (
      .lp (lane_bus.lane)
   );

   assign dec         = dmx_decode(insn_data[15:8]);
   // no take while a resource load still drives its channel
   assign insn_ready  = (r.state == st_idle && !r.res_we) || (r.state == st_opnd);
   assign take        = insn_valid && (r.state == st_idle) && !r.res_we;
   assign gpr_rd_addr = insn_data[3:0];
   assign res_channel = (r.state == st_idle && !r.res_we) ? insn_data[7:4] : r.chan;
   assign res_re      = take && (dec.kind == k_res_st);
   assign flags_we    = 1'b0;

   // offset scaling and pointer arithmetic for the instruction on offer
   always_comb begin
      unique case (dec.size)
         sz_word: dir_w = {22'h00_0000, insn_data[7:0], 2'h0};
         sz_half: dir_w = {23'h00_0000, insn_data[7:0], 1'h0};
         default: dir_w = {24'h00_0000, insn_data[7:0]};
      endcase
      unique case (dec.size)
         sz_word: step = `DMX_STEP_WORD;
         sz_half: step = `DMX_STEP_HALF;
         default: step = `DMX_STEP_BYTE;
      endcase
      if (dec.use_stack) begin
         ptr_base = r15_value;
      end else if (dec.kind == k_res_ld || dec.kind == k_res_st) begin
         ptr_base = gpr_rd_data;
      end else begin
         ptr_base = r13_value;
      end
      if (dec.use_stack && dec.kind == k_dir_ptr) begin
         ptr_a = ptr_base - `DMX_STEP_WORD;
         ptr_n = ptr_a;
      end else begin
         ptr_a = ptr_base;
         ptr_n = ptr_base + step;
      end
   end

   // lane formatter hookup
   always_comb begin
      lane_bus.rd_raw = mem_rdata;
      lane_bus.rd_lo  = r.mem_addr[1:0];
      if (r.state == st_idle) begin
         lane_bus.size   = dec.size;
         lane_bus.wr_val = (dec.kind == k_res_st) ? res_rdata : r13_value;
         lane_bus.acc_lo = (dec.kind == k_load || dec.kind == k_store ||
                            dec.kind == k_dir_ptr) ? dir_w[1:0] : ptr_a[1:0];
      end else begin
         lane_bus.size   = r.size;
         lane_bus.wr_val = lane_bus.rd_ext;
         lane_bus.acc_lo = (r.kind == k_dir_ptr) ? r.ptr_addr[1:0] : r.dir_addr[1:0];
      end
   end

   always_comb begin
      next_r             = r;
      next_r.done        = 1'b0;
      next_r.unknown     = 1'b0;
      next_r.gpr_we      = 1'b0;
      next_r.res_we      = 1'b0;
      next_r.trap_absent = 1'b0;
      next_r.trap_error  = 1'b0;
      unique case (r.state)
         st_idle: begin
            if (take) begin
               next_r.kind      = dec.kind;
               next_r.size      = dec.size;
               next_r.use_stack = dec.use_stack;
               next_r.dir_addr  = dir_w;
               next_r.ptr_addr  = ptr_a;
               next_r.ptr_next  = ptr_n;
               next_r.chan      = insn_data[7:4];
               next_r.mem_be    = lane_bus.be;
               next_r.mem_wdata = lane_bus.wr_lanes;
               if (dec.use_stack) begin
                  next_r.ptr_reg = `DMX_REG_STACK;
               end else if (dec.kind == k_res_ld || dec.kind == k_res_st) begin
                  next_r.ptr_reg = insn_data[3:0];
               end else begin
                  next_r.ptr_reg = `DMX_REG_XFER;
               end
               unique case (dec.kind)
                  k_none: begin
                     next_r.unknown = 1'b1;
                  end
                  k_cop: begin
                     if (insn_data[15:4] == `DMX_OP_COP) begin
                        next_r.chan  = insn_data[3:0];
                        next_r.state = st_opnd;
                     end else begin
                        next_r.unknown = 1'b1;
                     end
                  end
                  k_load, k_dir_ptr: begin
                     next_r.mem_req  = 1'b1;
                     next_r.mem_we   = 1'b0;
                     next_r.mem_addr = dir_w;
                     next_r.state    = st_mem1;
                  end
                  k_store: begin
                     next_r.mem_req  = 1'b1;
                     next_r.mem_we   = 1'b1;
                     next_r.mem_addr = dir_w;
                     next_r.state    = st_mem1;
                  end
                  k_ptr_dir, k_res_ld: begin
                     next_r.mem_req  = 1'b1;
                     next_r.mem_we   = 1'b0;
                     next_r.mem_addr = ptr_a;
                     next_r.state    = st_mem1;
                  end
                  default: begin
                     next_r.mem_req  = 1'b1;
                     next_r.mem_we   = 1'b1;
                     next_r.mem_addr = ptr_a;
                     next_r.state    = st_mem1;
                  end
               endcase
            end
         end
         st_opnd: begin
            if (insn_valid) begin
               next_r.cop_cmd = insn_data;
               next_r.state   = st_copchk;
            end
         end
         st_copchk: begin
            if (!cop_present[r.chan]) begin
               next_r.trap_absent = 1'b1;
               next_r.state       = st_idle;
            end else if (cop_error[r.chan]) begin
               next_r.trap_error = 1'b1;
               next_r.state      = st_idle;
            end else begin
               next_r.cop_req = 1'b1;
               next_r.state   = st_copsend;
            end
         end
         st_copsend: begin
            if (cop_ack) begin
               next_r.cop_req = 1'b0;
               next_r.done    = 1'b1;
               next_r.state   = st_idle;
            end
         end
         st_mem1: begin
            if (mem_ack) begin
               next_r.mem_req = 1'b0;
               next_r.state   = st_idle;
               unique case (r.kind)
                  k_load: begin
                     next_r.gpr_we    = 1'b1;
                     next_r.gpr_waddr = `DMX_REG_XFER;
                     next_r.gpr_wdata = lane_bus.rd_ext;
                     next_r.done      = 1'b1;
                  end
                  k_dir_ptr, k_ptr_dir: begin
                     next_r.mem_req   = 1'b1;
                     next_r.mem_we    = 1'b1;
                     next_r.mem_addr  = (r.kind == k_dir_ptr) ? r.ptr_addr : r.dir_addr;
                     next_r.mem_be    = lane_bus.be;
                     next_r.mem_wdata = lane_bus.wr_lanes;
                     next_r.state     = st_mem2;
                  end
                  k_res_ld, k_res_st: begin
                     next_r.res_we    = (r.kind == k_res_ld);
                     next_r.res_wdata = mem_rdata;
                     next_r.gpr_we    = 1'b1;
                     next_r.gpr_waddr = r.ptr_reg;
                     next_r.gpr_wdata = r.ptr_next;
                     next_r.done      = 1'b1;
                  end
                  default: begin
                     next_r.done = 1'b1;
                  end
               endcase
            end
         end
         st_mem2: begin
            if (mem_ack) begin
               next_r.mem_req   = 1'b0;
               next_r.gpr_we    = 1'b1;
               next_r.gpr_waddr = r.ptr_reg;
               next_r.gpr_wdata = r.ptr_next;
               next_r.done      = 1'b1;
               next_r.state     = st_idle;
            end
         end
         default: begin
            next_r.state = st_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign insn_done    = r.done;
   assign insn_unknown = r.unknown;
   assign gpr_we       = r.gpr_we;
   assign gpr_waddr    = r.gpr_waddr;
   assign gpr_wdata    = r.gpr_wdata;
   assign mem_req      = r.mem_req;
   assign mem_we       = r.mem_we;
   assign mem_addr     = r.mem_addr;
   assign mem_be       = r.mem_be;
   assign mem_wdata    = r.mem_wdata;
   assign res_we       = r.res_we;
   assign res_wdata    = r.res_wdata;
   assign cop_req      = r.cop_req;
   assign cop_channel  = r.chan;
   assign cop_cmd      = r.cop_cmd;
   assign trap_absent  = r.trap_absent;
   assign trap_error   = r.trap_error;

   // checks
   sequence s_take(logic [7:0] op);
      take && insn_data[15:8] == op;
   endsequence

   property p_push_order;
      s_take(`DMX_OP_PUSH_W) |=> !mem_we && mem_addr == r.dir_addr && r.ptr_addr == $past(r15_value) - 32'h4;
   endproperty
   a_push_order: assert property (@(posedge core_clk) disable iff (reset) p_push_order)
      else $error("push does not predecrement the stack register");

   property p_pop_read;
      s_take(`DMX_OP_POP_W) |=> !mem_we && mem_addr == $past(r15_value) && r.ptr_next == $past(r15_value) + 32'h4;
   endproperty
   a_pop_read: assert property (@(posedge core_clk) disable iff (reset) p_pop_read)
      else $error("pop does not read at the stack register");

   property p_half_zero;
      gpr_we && r.kind == k_load && r.size == sz_half |-> gpr_wdata[31:16] == 16'h0000;
   endproperty
   a_half_zero: assert property (@(posedge core_clk) disable iff (reset) p_half_zero)
      else $error("half-word load not zero extended");

   property p_half_store;
      s_take(`DMX_OP_ST_H) |=> mem_we && mem_wdata[15:0] == $past(r13_value[15:0]) && mem_addr[0] == 1'b0;
   endproperty
   a_half_store: assert property (@(posedge core_clk) disable iff (reset) p_half_store)
      else $error("half-word store data or address wrong");

   property p_half_step;
      mem_ack && r.state == st_mem2 && r.size == sz_half && r.kind == k_dir_ptr
         |=> gpr_we && gpr_wdata == $past(mem_addr) + 32'h2;
   endproperty
   a_half_step: assert property (@(posedge core_clk) disable iff (reset) p_half_step)
      else $error("half-word pointer not advanced by two");

   property p_byte_zero;
      gpr_we && r.kind == k_load && r.size == sz_byte |-> gpr_wdata[31:8] == 24'h00_0000;
   endproperty
   a_byte_zero: assert property (@(posedge core_clk) disable iff (reset) p_byte_zero)
      else $error("byte load not zero extended");

   property p_byte_step;
      mem_ack && r.state == st_mem2 && r.size == sz_byte && r.kind == k_dir_ptr
         |=> gpr_we && gpr_wdata == $past(mem_addr) + 32'h1;
   endproperty
   a_byte_step: assert property (@(posedge core_clk) disable iff (reset) p_byte_step)
      else $error("byte pointer not advanced by one");

   property p_load_done;
      mem_ack && r.state == st_mem1 && r.kind == k_load |=> insn_done && gpr_we && gpr_waddr == `DMX_REG_XFER;
   endproperty
   a_load_done: assert property (@(posedge core_clk) disable iff (reset) p_load_done)
      else $error("load did not finish after its access");

   property p_flags;
      flags_we == 1'b0;
   endproperty
   a_flags: assert property (@(posedge core_clk) disable iff (reset) p_flags)
      else $error("condition flags written");

   property p_res_send;
      mem_ack && r.state == st_mem1 && r.kind == k_res_ld
         |=> res_we && res_wdata == $past(mem_rdata) && res_channel == r.chan;
   endproperty
   a_res_send: assert property (@(posedge core_clk) disable iff (reset) p_res_send)
      else $error("resource load data not delivered");

   property p_cop_cmd;
      r.state == st_opnd && insn_valid ##1 r.state == st_copchk && cop_present[r.chan] && !cop_error[r.chan]
         |=> cop_req && cop_cmd == $past(insn_data, 2);
   endproperty
   a_cop_cmd: assert property (@(posedge core_clk) disable iff (reset) p_cop_cmd)
      else $error("coprocessor command not issued");

   property p_absent;
      r.state == st_copchk && !cop_present[r.chan] |=> trap_absent && !cop_req && !insn_done;
   endproperty
   a_absent: assert property (@(posedge core_clk) disable iff (reset) p_absent)
      else $error("absent coprocessor not trapped");

   property p_cop_err;
      r.state == st_copchk && cop_present[r.chan] && cop_error[r.chan] |=> trap_error && !cop_req;
   endproperty
   a_cop_err: assert property (@(posedge core_clk) disable iff (reset) p_cop_err)
      else $error("coprocessor error not trapped");

endmodule : dmx_exec

// file: rtl/dmx_lane.sv
// Purpose: zero-extends read data and places write data on byte lanes
// Assumes: address low bits aligned to the access size
// Notes: combinational
`timescale 1ns/100ps
`include "dmx_defs.svh"
module dmx_lane (
   // formatter side
   dmx_lane_if.lane lp
);
   import dmx_pkg::*;

   logic [7:0] rd_bytes [4];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_bytes
         assign rd_bytes[g] = lp.rd_raw[31-8*g -: 8];
      end
   endgenerate

   always_comb begin
      unique case (lp.size)
         sz_word: begin
            lp.rd_ext   = lp.rd_raw;
            lp.wr_lanes = lp.wr_val;
            lp.be       = `DMX_BE_WORD;
         end
         sz_half: begin
            lp.rd_ext   = {16'h0000, rd_bytes[{lp.rd_lo[1], 1'b0}], rd_bytes[{lp.rd_lo[1], 1'b1}]};
            lp.wr_lanes = {2{lp.wr_val[15:0]}};
            lp.be       = lp.acc_lo[1] ? `DMX_BE_HALF_LO : `DMX_BE_HALF_HI;
         end
         default: begin
            lp.rd_ext   = {24'h00_0000, rd_bytes[lp.rd_lo]};
            lp.wr_lanes = {4{lp.wr_val[7:0]}};
            lp.be       = `DMX_BE_BYTE_TOP >> lp.acc_lo;
         end
      endcase
   end

endmodule : dmx_lane

// file: rtl/dmx_lane_if.sv
// Purpose: carries sizing and lane data between executor and lane formatter
// Assumes: purely combinational signals on the core clock
// Notes: big-endian byte numbering
`timescale 1ns/100ps
interface dmx_lane_if;
   import dmx_pkg::*;
   dmx_size_type size;
   logic [1:0]   acc_lo;
   logic [1:0]   rd_lo;
   logic [31:0]  rd_raw;
   logic [31:0]  rd_ext;
   logic [31:0]  wr_val;
   logic [31:0]  wr_lanes;
   logic [3:0]   be;

   modport exec (output size, acc_lo, rd_lo, rd_raw, wr_val, input rd_ext, wr_lanes, be);
   modport lane (input size, acc_lo, rd_lo, rd_raw, wr_val, output rd_ext, wr_lanes, be);
endinterface : dmx_lane_if

// file: rtl/dmx_pkg.sv
// Purpose: types shared by the execution unit and its lane formatter
// Assumes: dmx_defs.svh supplies the constants
// Notes: decode function lives here
`include "dmx_defs.svh"
package dmx_pkg;

   typedef enum logic [1:0] {sz_word, sz_half, sz_byte} dmx_size_type;

   typedef enum logic [2:0] {k_none, k_load, k_store, k_dir_ptr, k_ptr_dir,
                             k_res_ld, k_res_st, k_cop} dmx_kind_type;

   typedef enum logic [2:0] {st_idle, st_opnd, st_copchk, st_copsend,
                             st_mem1, st_mem2} dmx_state_type;

   typedef struct packed {
      dmx_kind_type kind;
      dmx_size_type size;
      logic         use_stack;
   } dmx_dec_type;

   // classify an instruction from its upper byte
   function automatic dmx_dec_type dmx_decode(input logic [7:0] op);
      dmx_dec_type d;
      d = '{k_none, sz_word, 1'b0};
      unique case (op)
         `DMX_OP_LD_W:   d = '{k_load,    sz_word, 1'b0};
         `DMX_OP_ST_W:   d = '{k_store,   sz_word, 1'b0};
         `DMX_OP_DP_W:   d = '{k_dir_ptr, sz_word, 1'b0};
         `DMX_OP_PD_W:   d = '{k_ptr_dir, sz_word, 1'b0};
         `DMX_OP_PUSH_W: d = '{k_dir_ptr, sz_word, 1'b1};
         `DMX_OP_POP_W:  d = '{k_ptr_dir, sz_word, 1'b1};
         `DMX_OP_LD_H:   d = '{k_load,    sz_half, 1'b0};
         `DMX_OP_ST_H:   d = '{k_store,   sz_half, 1'b0};
         `DMX_OP_DP_H:   d = '{k_dir_ptr, sz_half, 1'b0};
         `DMX_OP_PD_H:   d = '{k_ptr_dir, sz_half, 1'b0};
         `DMX_OP_LD_B:   d = '{k_load,    sz_byte, 1'b0};
         `DMX_OP_ST_B:   d = '{k_store,   sz_byte, 1'b0};
         `DMX_OP_DP_B:   d = '{k_dir_ptr, sz_byte, 1'b0};
         `DMX_OP_PD_B:   d = '{k_ptr_dir, sz_byte, 1'b0};
         `DMX_OP_RES_LD: d = '{k_res_ld,  sz_word, 1'b0};
         `DMX_OP_RES_ST: d = '{k_res_st,  sz_word, 1'b0};
         default: begin
            if (op == 8'(`DMX_OP_COP >> 4)) begin
               d = '{k_cop, sz_word, 1'b0};
            end
         end
      endcase
      return d;
   endfunction : dmx_decode

endpackage : dmx_pkg

// file: tb/dmx_far.sv
// Purpose: memory, resource and coprocessor far side
// Assumes: one access at a time, ack one cycle after request
// Notes: idle data lines show inverted value
`timescale 1ns/100ps
module dmx_far (
   // clock
   input  wire logic        core_clk,
   // memory
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  mem_be,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata,
   output logic             mem_ack = 1'b0,
   // resource and coprocessor
   input  wire logic [3:0]  res_channel,
   input  wire logic        res_re,
   output logic      [31:0] res_rdata,
   input  wire logic        cop_req,
   input  wire logic [15:0] cop_cmd,
   output logic             cop_ack = 1'b0
);
   logic [7:0]  m [0:1023];
   logic [31:0] cr [0:15];
   logic [9:0]  b;
   logic [31:0] w;
   assign b = {mem_addr[9:2], 2'h0};
   assign w = {m[b], m[b+10'h1], m[b+10'h2], m[b+10'h3]};
   assign mem_rdata = mem_ack ? w : ~w;
   assign res_rdata = {28'hd00d5e0, res_channel} ^ {32{~res_re}};
   always @(posedge core_clk) begin
      mem_ack <= mem_req & ~mem_ack;
      cop_ack <= cop_req & ~cop_ack;
      for (int i = 0; i < 4; i++) begin
         if (mem_req & mem_ack & mem_we & mem_be[3-i]) begin
            m[b+10'(i)] <= mem_wdata[31-8*i -: 8];
         end
      end
      if (cop_req & cop_ack) begin
         case (cop_cmd[15:8])
            8'h00: cr[cop_cmd[3:0]] <= cr[cop_cmd[3:0]] + cr[cop_cmd[7:4]];
            8'h01: cr[cop_cmd[3:0]] <= cr[cop_cmd[3:0]] - cr[cop_cmd[7:4]];
            8'h02: cr[cop_cmd[3:0]] <= cr[cop_cmd[3:0]] * cr[cop_cmd[7:4]];
            default: ;
         endcase
      end
   end
endmodule : dmx_far

// file: tb/tb.sv
// Purpose: directed bench for the execution unit
// Assumes: far side makes a two cycles
// Notes: counts run from take to done
`timescale 1ns/100ps
module tb;
   localparam int A = 2;
   logic core_clk = 0, reset = 1, insn_valid = 0, fl;
   logic [15:0] insn_data = 0, cop_present = 16'h8000, cop_error = 0, cop_cmd, cc;
   logic [31:0] r13_value = 0, r15_value = 0, gpr_rd_data, gpr_wdata, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] res_rdata, res_wdata, rw, gd, gpr [0:15];
   logic insn_ready, insn_done, insn_unknown, gpr_we, flags_we, mem_req, mem_we, mem_ack, res_re, res_we;
   logic cop_req, cop_ack, trap_absent, trap_error;
   logic [3:0] gpr_rd_addr, gpr_waddr, mem_be, res_channel, cop_channel, gw, ch;
   logic [1:0] e;
   int failures = 0, num_checks = 0;
   assign gpr_rd_data = gpr[gpr_rd_addr];
   dmx_exec DUT (.core_clk, .reset, .insn_valid, .insn_data, .insn_ready, .insn_done, .insn_unknown,
      .r13_value, .r15_value, .gpr_rd_addr, .gpr_rd_data, .gpr_we, .gpr_waddr, .gpr_wdata, .flags_we,
      .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack, .res_channel, .res_re,
      .res_rdata, .res_we, .res_wdata, .cop_present, .cop_error, .cop_req, .cop_channel, .cop_cmd,
      .cop_ack, .trap_absent, .trap_error);
   dmx_far far (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack,
      .res_channel, .res_re, .res_rdata, .cop_req, .cop_cmd, .cop_ack);
   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic ck(input bit ok, input string s);
      num_checks++;
      if (!ok) begin
         failures++;
         $display("[FAIL] %0t %s", $time, s);
      end
   endtask : ck
   task automatic wm(input int a, input logic [31:0] v);
      for (int i = 0; i < 4; i++) far.m[a+i] = v[31-8*i -: 8];
   endtask : wm
   task automatic t(input logic [15:0] h1, h2, input logic [31:0] r, input int cyc, input logic [1:0] ev,
                    input logic [3:0] wa, input logic [31:0] wd, input int ma, na, input logic [31:0] mv);
      int n;
      logic [31:0] q;
      n = 0;
      q = 0;
      gw = 0;
      fl = 0;
      @(posedge core_clk);
      insn_valid <= 1'b1;
      insn_data <= h1;
      r13_value <= r;
      r15_value <= r;
      do @(negedge core_clk); while (insn_ready !== 1'b1);
      @(posedge core_clk);
      insn_valid <= h2 != 0;
      insn_data <= h2;
      while (n < 40) begin
         @(negedge core_clk);
         n++;
         fl |= flags_we;
         if (gpr_we) begin
            gw = gpr_waddr;
            gd = gpr_wdata;
            gpr[gpr_waddr] = gpr_wdata;
         end
         if (res_we) {rw, ch} = {res_wdata, res_channel};
         if (cop_req) {cc, ch} = {cop_cmd, cop_channel};
         e = trap_absent ? 2'h1 : trap_error ? 2'h2 : insn_unknown ? 2'h3 : 2'h0;
         if (insn_done || e != 0) break;
         @(posedge core_clk);
         insn_valid <= 1'b0;
      end
      for (int i = 0; i < na; i++) q = {q[23:0], far.m[ma+i]};
      ck(n === cyc && e === ev && fl === 1'b0, "count or event");
      if (wa != 0) ck(gw === wa && gd === wd, "register");
      if (na != 0) ck(q === mv, "memory");
      $display("test %h ended", h1);
   endtask : t
   initial forever #10 core_clk = ~core_clk;
   initial begin
      #20000;
      failures++;
      end_of_test;
   end
   initial begin
      wm(32'h88, 32'h11223344);
      wm(32'h2c, 32'ha1b2c3d4);
      wm(32'h300, 32'h55667788);
      wm(32'h120, 32'h01020304);
      far.m[32'h91] = 8'h32;
      far.m[32'h71] = 8'h9e;
      gpr[2] = 32'h120;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      t(16'h0822, 0, 0, A+1, 0, 13, 32'h11223344, 0, 0, 0);
      t(16'h1815, 0, 32'hcafef00d, A+1, 0, 0, 0, 32'h54, 4, 32'hcafef00d);
      t(16'h0b0b, 0, 32'h200, 2*A+1, 0, 15, 32'h1fc, 32'h1fc, 4, 32'ha1b2c3d4);
      t(16'h1b0e, 0, 32'h300, 2*A+1, 0, 15, 32'h304, 32'h38, 4, 32'h55667788);
      t(16'h0944, 0, 0, A+1, 0, 13, 32'h1122, 0, 0, 0);
      t(16'h1929, 0, 32'hffffae86, A+1, 0, 0, 0, 32'h52, 4, 32'hae86cafe);
      t(16'h0d44, 0, 32'h100, 2*A+1, 0, 13, 32'h102, 32'h100, 2, 32'h1122);
      t(16'h1d29, 0, 32'h100, 2*A+1, 0, 13, 32'h102, 32'h52, 4, 32'h1122cafe);
      t(16'h0a91, 0, 0, A+1, 0, 13, 32'h32, 0, 0, 0);
      t(16'h1a53, 0, 32'h1234565a, A+1, 0, 0, 0, 32'h52, 4, 32'h115acafe);
      t(16'h0e71, 0, 32'h101, 2*A+1, 0, 13, 32'h102, 32'h100, 2, 32'h119e);
      t(16'h1e57, 0, 32'h100, 2*A+1, 0, 13, 32'h101, 32'h57, 1, 32'h11);
      t(16'h0c22, 0, 32'h140, 2*A+1, 0, 13, 32'h144, 32'h140, 4, 32'h11223344);
      t(16'h1c60, 0, 32'h140, 2*A+1, 0, 13, 32'h144, 32'h180, 4, 32'h11223344);
      t(16'hbc82, 0, 0, A+1, 0, 2, 32'h124, 0, 0, 0);
      ck(rw === 32'h01020304 && ch === 4'h8, "resource data");
      t(16'hbd82, 0, 0, A+1, 0, 2, 32'h128, 32'h124, 4, 32'hd00d5e08);
      t(16'h9fcf, 16'h0134, 0, A+3, 0, 0, 0, 0, 0, 0);
      ck(cc === 16'h0134 && ch === 4'hf, "command");
      cop_present <= 16'h0;
      t(16'h9fcf, 16'h0134, 0, 3, 1, 0, 0, 0, 0, 0);
      cop_present <= 16'h8000;
      cop_error <= 16'h8000;
      t(16'h9fcf, 16'h0134, 0, 3, 2, 0, 0, 0, 0, 0);
      t(16'hff00, 0, 0, 1, 3, 0, 0, 0, 0, 0);
      t(16'h9f12, 0, 0, 1, 3, 0, 0, 0, 0, 0);
      end_of_test;
   end
endmodule : tb
